/* core/vlt_pkg.sv */
// Constants, register map and carrier types of the VBI line timing block
package vlt_pkg;

  // Register subaddresses
  localparam logic [7:0] ADDR_CAPTION_TELETEXT_CONTROL = 8'h6F;
  localparam logic [7:0] ADDR_REF_PULSE_WINDOW_A = 8'h70;
  localparam logic [7:0] ADDR_REF_PULSE_WINDOW_B = 8'h71;
  localparam logic [7:0] ADDR_REF_PULSE_WINDOW_C = 8'h72;
  localparam logic [7:0] ADDR_TELETEXT_REQUEST_START = 8'h73;
  localparam logic [7:0] ADDR_TELETEXT_DATA_DELAY = 8'h74;
  localparam logic [7:0] ADDR_VSYNC_SHIFT = 8'h75;
  localparam logic [7:0] ADDR_TELETEXT_ODD_LINES_A = 8'h76;
  localparam logic [7:0] ADDR_TELETEXT_ODD_LINES_B = 8'h77;
  localparam logic [7:0] ADDR_TELETEXT_EVEN_LINES_A = 8'h78;
  localparam logic [7:0] ADDR_TELETEXT_EVEN_LINES_B = 8'h79;
  localparam logic [7:0] ADDR_ACTIVE_LINE_FIRST = 8'h7A;
  localparam logic [7:0] ADDR_ACTIVE_LINE_LAST = 8'h7B;
  localparam logic [7:0] ADDR_LINE_HIGH_BITS_AND_TELETEXT_STD = 8'h7C;
  localparam int REG_COUNT = 14;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions in caption_teletext_control
  localparam int CAPTION_ENABLE_HI = 7;
  localparam int CAPTION_ENABLE_LO = 6;
  localparam int TELETEXT_INSERT_ENABLE_BIT = 5;
  localparam int CAPTION_LINE_SELECT_HI = 4;
  // Field positions in ref_pulse_window_c
  localparam int REF_PULSE_END_HI = 6;
  localparam int REF_PULSE_END_LO = 4;
  localparam int REF_PULSE_START_HI = 2;
  // Field positions in line_high_bits_and_teletext_std
  localparam int ODD_FIRST_HI_BIT = 0;
  localparam int ODD_LAST_HI_BIT = 1;
  localparam int EVEN_FIRST_HI_BIT = 2;
  localparam int EVEN_LAST_HI_BIT = 3;
  localparam int FIRST_ACTIVE_HI_BIT = 4;
  localparam int TELETEXT_STANDARD_SEL_BIT = 5;
  localparam int LAST_ACTIVE_HI_BIT = 6;

  // Line geometry, in pixel clocks and lines
  localparam logic [10:0] PIX_LAST_60 = 11'h06B3;
  localparam logic [10:0] PIX_LAST_50 = 11'h06BF;
  localparam logic [8:0] LINES_LONG_60 = 9'h0107;
  localparam logic [8:0] LINES_SHORT_60 = 9'h0106;
  localparam logic [8:0] LINES_LONG_50 = 9'h0139;
  localparam logic [8:0] LINES_SHORT_50 = 9'h0138;
  localparam logic [8:0] OFFSET_FIRST_M = 9'h0004;
  localparam logic [8:0] OFFSET_FIRST_OTHER = 9'h0001;
  localparam logic [8:0] OFFSET_LAST_M = 9'h0003;
  localparam logic [8:0] OFFSET_LAST_OTHER = 9'h0000;
  // Forced standard blanking window, counted from field sync as line 0
  localparam logic [8:0] STD_FIRST_ACTIVE_60 = 9'h0014;
  localparam logic [8:0] STD_LAST_ACTIVE_60 = 9'h0105;
  localparam logic [8:0] STD_FIRST_ACTIVE_50 = 9'h0017;
  localparam logic [8:0] STD_LAST_ACTIVE_50 = 9'h0136;
  localparam logic [8:0] VSYNC_LINES = 9'h0003;

  // Teletext request and sampling
  localparam logic [8:0] TTX_REQ_CLKS = 9'h0010;
  localparam logic [8:0] TTX_MIN_DELAY = 9'h0002;
  localparam int TTX_BUF_DEPTH = 2;
  localparam int TTX_WORD_W = 1;

  // Field length codes
  localparam logic [1:0] FLC_INTERLACED = 2'h0;
  localparam logic [1:0] FLC_SHORT = 2'h1;
  // Teletext standard reported to the inserter
  localparam logic [1:0] TTX_STD_EUROPEAN = 2'h0;
  localparam logic [1:0] TTX_STD_NABTS = 2'h1;
  localparam logic [1:0] TTX_STD_WORLD60 = 2'h2;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } vlt_regwr_t;

  typedef struct packed {
    logic fieldRateSelect;
    logic [1:0] fieldLengthCtrl;
    logic standardBlankingForce;
    logic compositeBlankSelect;
    logic syncPinAOutEn;
    logic syncPinBOutEn;
  } vlt_pincfg_t;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic [7:0] rdData;
    logic [10:0] pix;
    logic [8:0] line;
    logic evenField;
    logic hrefOn;
    logic vsyncOn;
    logic activeLine;
    logic captionLine;
    logic reqBusy;
    logic [8:0] reqCnt;
    logic teletextRequest;
    logic [2:0] pinSync;
    logic ttxStable;
    logic [TTX_BUF_DEPTH-1:0][TTX_WORD_W-1:0] bitQ;
    logic [1:0] bufCnt;
  } vlt_state_t;

endpackage

/* core/vlt_line_timing.sv */
// VBI line timing: field/line counters, reference pulses, caption and teletext scheduling
//
// How it works
// RQ1: Code 00 gives interlaced 312.5/262.5 line fields
// RQ2: Code 01 312/262, codes 1x 313/263 lines
// RQ3: Teletext insertion off until enable bit set
// RQ4: Caption line is select plus 4 or 1
// RQ5: Caption enable picks none, odd, even, both
// RQ6: Reference pulse begins at programmed start count
// RQ7: Start 11AH/0FDH aligns with first active pixel
// RQ8: Reference pulse ends at programmed end count
// RQ9: Teletext request starts at programmed horizontal position
// RQ10: Teletext data sampled delay clocks after request
// RQ11: Vertical sync shifted against horizontal by shift
// RQ12: Odd teletext first line is value plus 4/1
// RQ13: Odd teletext last line is value plus 3/0
// RQ14: Even teletext first line is value plus 4/1
// RQ15: Even teletext last line is value plus 3/0
// RQ16: First active line is value plus 4/1
// RQ17: Last active line is value plus 3/0
// RQ18: Standard bit picks NABTS or world 60 Hz at 60 Hz; 50 Hz is always European
// RQ19: Blanking from active lines or forced standard
// RQ20: Pin B carries reference pulse, optionally blanking-gated
// RQ21: Line mask only narrows enabled teletext lines
// RQ22: Field-rate bit selects 60 Hz numbering and limits
// RQ23: Pixel counter restarts each line, compared every clock
module vlt_line_timing (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Subaddressed register access
  input wire vlt_pkg::vlt_regwr_t regWr,
  input wire logic [7:0] regRdAddr,
  output logic [7:0] regRdData,
  // Pin-level configuration bits held outside this block
  input wire vlt_pkg::vlt_pincfg_t pinCfg,
  input wire logic [1:0] syncPinAType,
  // Sync pins, three signals each
  input wire logic syncPinAIn,
  output logic syncPinAOut,
  output logic syncPinAOe,
  input wire logic syncPinBIn,
  output logic syncPinBOut,
  output logic syncPinBOe,
  // Teletext source link
  output logic teletextRequestOut,
  input wire logic teletextDataIn,
  input wire logic [1:0] teletextLineMaskOff,
  // Teletext bit stream toward the inserter
  output logic ttxBitValid,
  input wire logic ttxBitReady,
  output logic [vlt_pkg::TTX_WORD_W-1:0] ttxBitData,
  output logic ttxBufReady,
  output logic [1:0] teletextStandard,
  output logic teletextInsertOn,
  // Video timing toward the encoder
  output logic activeLine,
  output logic captionLine,
  output logic evenField,
  output logic [8:0] lineCount,
  output logic [10:0] pixelCount
);

  vlt_pkg::vlt_state_t state_r;
  vlt_pkg::vlt_state_t state_nxt;

  function automatic logic [7:0] regAt(input vlt_pkg::vlt_state_t s, input logic [7:0] addr);
    regAt = s.regs[addr - vlt_pkg::ADDR_CAPTION_TELETEXT_CONTROL];
  endfunction

  // Start-of-window line from a programmed value
  function automatic logic [8:0] firstLine(input logic [8:0] v, input logic m);
    firstLine = v + (m ? vlt_pkg::OFFSET_FIRST_M : vlt_pkg::OFFSET_FIRST_OTHER);
  endfunction

  // End-of-window line from a programmed value
  function automatic logic [8:0] lastLine(input logic [8:0] v, input logic m);
    lastLine = v + (m ? vlt_pkg::OFFSET_LAST_M : vlt_pkg::OFFSET_LAST_OTHER);
  endfunction

  function automatic logic inWindow(input logic [8:0] l, input logic [8:0] f,
                                    input logic [8:0] e);
    inWindow = (l >= f) && (l <= e);
  endfunction

  // Decoded register fields
  logic mSys;
  logic [7:0] ctrlReg;
  logic [7:0] hiReg;
  logic [7:0] winC;
  logic [10:0] refStart;
  logic [10:0] refEnd;
  logic [10:0] reqStart;
  logic [10:0] vsShift;
  logic [8:0] reqDelay;
  logic [8:0] sampleEnd;
  logic [8:0] oddFirst;
  logic [8:0] oddLast;
  logic [8:0] evenFirst;
  logic [8:0] evenLast;
  logic [8:0] actFirst;
  logic [8:0] actLast;
  logic [8:0] captionAt;
  logic [10:0] pixLast;
  logic [8:0] fieldLines;
  logic ttxLineOn;
  logic captionFieldOn;
  logic lineEnd;
  logic sampleNow;
  logic popNow;
  logic pushNow;

  always_comb begin
    ctrlReg = regAt(state_r, vlt_pkg::ADDR_CAPTION_TELETEXT_CONTROL);
    hiReg = regAt(state_r, vlt_pkg::ADDR_LINE_HIGH_BITS_AND_TELETEXT_STD);
    winC = regAt(state_r, vlt_pkg::ADDR_REF_PULSE_WINDOW_C);
    mSys = pinCfg.fieldRateSelect; // RQ22
    refStart = {winC[vlt_pkg::REF_PULSE_START_HI:0],
                regAt(state_r, vlt_pkg::ADDR_REF_PULSE_WINDOW_A)};
    refEnd = {winC[vlt_pkg::REF_PULSE_END_HI:vlt_pkg::REF_PULSE_END_LO],
              regAt(state_r, vlt_pkg::ADDR_REF_PULSE_WINDOW_B)};
    reqStart = {3'h0, regAt(state_r, vlt_pkg::ADDR_TELETEXT_REQUEST_START)};
    vsShift = {3'h0, regAt(state_r, vlt_pkg::ADDR_VSYNC_SHIFT)};
    reqDelay = {1'b0, regAt(state_r, vlt_pkg::ADDR_TELETEXT_DATA_DELAY)};
    // A delay below the minimum would sample before the source can answer
    if (reqDelay < vlt_pkg::TTX_MIN_DELAY) begin
      reqDelay = vlt_pkg::TTX_MIN_DELAY; // RQ10
    end
    sampleEnd = reqDelay + vlt_pkg::TTX_REQ_CLKS;
    oddFirst = firstLine({hiReg[vlt_pkg::ODD_FIRST_HI_BIT],
                          regAt(state_r, vlt_pkg::ADDR_TELETEXT_ODD_LINES_A)}, mSys); // RQ12
    oddLast = lastLine({hiReg[vlt_pkg::ODD_LAST_HI_BIT],
                        regAt(state_r, vlt_pkg::ADDR_TELETEXT_ODD_LINES_B)}, mSys); // RQ13
    evenFirst = firstLine({hiReg[vlt_pkg::EVEN_FIRST_HI_BIT],
                           regAt(state_r, vlt_pkg::ADDR_TELETEXT_EVEN_LINES_A)}, mSys); // RQ14
    evenLast = lastLine({hiReg[vlt_pkg::EVEN_LAST_HI_BIT],
                         regAt(state_r, vlt_pkg::ADDR_TELETEXT_EVEN_LINES_B)}, mSys); // RQ15
    if (pinCfg.standardBlankingForce) begin
      actFirst = mSys ? vlt_pkg::STD_FIRST_ACTIVE_60 : vlt_pkg::STD_FIRST_ACTIVE_50; // RQ19
      actLast = mSys ? vlt_pkg::STD_LAST_ACTIVE_60 : vlt_pkg::STD_LAST_ACTIVE_50; // RQ19
    end else begin
      actFirst = firstLine({hiReg[vlt_pkg::FIRST_ACTIVE_HI_BIT],
                            regAt(state_r, vlt_pkg::ADDR_ACTIVE_LINE_FIRST)}, mSys); // RQ16
      actLast = lastLine({hiReg[vlt_pkg::LAST_ACTIVE_HI_BIT],
                          regAt(state_r, vlt_pkg::ADDR_ACTIVE_LINE_LAST)}, mSys); // RQ17
    end
    captionAt = firstLine({4'h0, ctrlReg[vlt_pkg::CAPTION_LINE_SELECT_HI:0]}, mSys); // RQ4
    pixLast = mSys ? vlt_pkg::PIX_LAST_60 : vlt_pkg::PIX_LAST_50;
    // Interlace makes the odd field the long one and the even field the short one
    unique case (pinCfg.fieldLengthCtrl)
      vlt_pkg::FLC_INTERLACED: begin
        if (mSys) begin
          fieldLines = state_r.evenField ? vlt_pkg::LINES_SHORT_60 : vlt_pkg::LINES_LONG_60; // RQ1
        end else begin
          fieldLines = state_r.evenField ? vlt_pkg::LINES_SHORT_50 : vlt_pkg::LINES_LONG_50; // RQ1
        end
      end
      vlt_pkg::FLC_SHORT: begin
        fieldLines = mSys ? vlt_pkg::LINES_SHORT_60 : vlt_pkg::LINES_SHORT_50; // RQ2
      end
      default: begin
        fieldLines = mSys ? vlt_pkg::LINES_LONG_60 : vlt_pkg::LINES_LONG_50; // RQ2
      end
    endcase
    // The mask can only take lines away from the odd/even windows
    ttxLineOn = (state_r.evenField ? inWindow(state_r.line, evenFirst, evenLast)
                                   : inWindow(state_r.line, oddFirst, oddLast))
                && !teletextLineMaskOff[state_r.evenField]; // RQ21
    unique case (ctrlReg[vlt_pkg::CAPTION_ENABLE_HI:vlt_pkg::CAPTION_ENABLE_LO])
      2'h0: captionFieldOn = 1'b0; // RQ5
      2'h1: captionFieldOn = !state_r.evenField; // RQ5
      2'h2: captionFieldOn = state_r.evenField; // RQ5
      2'h3: captionFieldOn = 1'b1; // RQ5
    endcase
    lineEnd = state_r.pix == pixLast; // RQ23
    sampleNow = state_r.reqBusy && (state_r.reqCnt >= reqDelay)
                && (state_r.reqCnt < sampleEnd); // RQ10
    popNow = (state_r.bufCnt != 2'h0) && ttxBitReady;
    pushNow = sampleNow && ((state_r.bufCnt != 2'h2) || popNow);
  end

  always_comb begin
    state_nxt = state_r;
    // Register file
    state_nxt.rdData = 8'h00;
    if ((regRdAddr >= vlt_pkg::ADDR_CAPTION_TELETEXT_CONTROL)
        && (regRdAddr <= vlt_pkg::ADDR_LINE_HIGH_BITS_AND_TELETEXT_STD)) begin
      state_nxt.rdData = regAt(state_r, regRdAddr);
    end
    if (regWr.en && (regWr.addr >= vlt_pkg::ADDR_CAPTION_TELETEXT_CONTROL)
        && (regWr.addr <= vlt_pkg::ADDR_LINE_HIGH_BITS_AND_TELETEXT_STD)) begin
      state_nxt.regs[regWr.addr - vlt_pkg::ADDR_CAPTION_TELETEXT_CONTROL] = regWr.data;
    end
    // Pixel and line counters
    if (lineEnd) begin
      state_nxt.pix = 11'h0000; // RQ23
      if (state_r.line >= fieldLines - 9'h0001) begin
        state_nxt.line = 9'h0000;
        state_nxt.evenField = (pinCfg.fieldLengthCtrl == vlt_pkg::FLC_INTERLACED)
                              ? !state_r.evenField : 1'b0; // RQ1
      end else begin
        state_nxt.line = state_r.line + 9'h0001;
      end
    end else begin
      state_nxt.pix = state_r.pix + 11'h0001; // RQ23
    end
    // Horizontal reference pulse on pin B
    if (state_r.pix == refStart) begin
      state_nxt.hrefOn = 1'b1; // RQ6
    end else if (state_r.pix == refEnd) begin
      state_nxt.hrefOn = 1'b0; // RQ8
    end
    // Vertical sync on pin A, displaced from the line start by the shift
    if (state_r.pix == vsShift) begin
      if (state_r.line == 9'h0000) begin
        state_nxt.vsyncOn = 1'b1; // RQ11
      end else if (state_r.line == vlt_pkg::VSYNC_LINES) begin
        state_nxt.vsyncOn = 1'b0; // RQ11
      end
    end
    state_nxt.activeLine = inWindow(state_r.line, actFirst, actLast); // RQ19
    state_nxt.captionLine = captionFieldOn && (state_r.line == captionAt); // RQ4
    // Teletext request and sampling window
    if (state_r.reqBusy) begin
      state_nxt.reqCnt = state_r.reqCnt + 9'h0001;
      if (state_r.reqCnt == sampleEnd) begin
        state_nxt.reqBusy = 1'b0;
      end
    end else if (ctrlReg[vlt_pkg::TELETEXT_INSERT_ENABLE_BIT] && ttxLineOn
                 && (state_r.pix == reqStart)) begin
      state_nxt.reqBusy = 1'b1; // RQ9
      state_nxt.reqCnt = 9'h0000; // RQ3
    end
    state_nxt.teletextRequest = state_nxt.reqBusy
                                && (state_nxt.reqCnt < vlt_pkg::TTX_REQ_CLKS); // RQ9
    // Pin input: third stage must confirm the second before the value is used
    state_nxt.pinSync = {state_r.pinSync[1:0], teletextDataIn};
    if (state_r.pinSync[1] == state_r.pinSync[2]) begin
      state_nxt.ttxStable = state_r.pinSync[2];
    end
    // Two-entry buffer; a bit sampled while it is full and not being read is dropped
    if (popNow) begin
      state_nxt.bitQ[0] = state_r.bitQ[1];
    end
    if (pushNow) begin
      state_nxt.bitQ[state_r.bufCnt - {1'b0, popNow}] = state_r.ttxStable; // RQ10
    end
    state_nxt.bufCnt = state_r.bufCnt + {1'b0, pushNow} - {1'b0, popNow};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs
  always_comb begin
    regRdData = state_r.rdData;
    syncPinAOe = pinCfg.syncPinAOutEn;
    syncPinAOut = state_r.vsyncOn;
    syncPinBOe = pinCfg.syncPinBOutEn;
    syncPinBOut = state_r.hrefOn
                  && (!pinCfg.compositeBlankSelect || state_r.activeLine); // RQ20
    teletextRequestOut = state_r.teletextRequest;
    ttxBitValid = state_r.bufCnt != 2'h0;
    ttxBitData = state_r.bitQ[0];
    ttxBufReady = state_r.bufCnt != 2'h2;
    teletextInsertOn = ctrlReg[vlt_pkg::TELETEXT_INSERT_ENABLE_BIT]; // RQ3
    if (!mSys) begin
      teletextStandard = vlt_pkg::TTX_STD_EUROPEAN; // RQ18
    end else if (hiReg[vlt_pkg::TELETEXT_STANDARD_SEL_BIT]) begin
      teletextStandard = vlt_pkg::TTX_STD_WORLD60; // RQ18
    end else begin
      teletextStandard = vlt_pkg::TTX_STD_NABTS; // RQ18
    end
    activeLine = state_r.activeLine;
    captionLine = state_r.captionLine;
    evenField = state_r.evenField;
    lineCount = state_r.line;
    pixelCount = state_r.pix;
  end

endmodule

/* verification/vlt_line_timing_sva.sv */
// Port assertions for the VBI line timing block
module vlt_line_timing_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register writes and configuration
  input wire vlt_pkg::vlt_regwr_t regWr,
  input wire vlt_pkg::vlt_pincfg_t pinCfg,
  // Observed outputs and stream handshake
  input wire logic syncPinAOut,
  input wire logic syncPinBOut,
  input wire logic teletextRequestOut,
  input wire logic ttxBitValid,
  input wire logic ttxBitReady,
  input wire logic [vlt_pkg::TTX_WORD_W-1:0] ttxBitData,
  input wire logic ttxBufReady,
  input wire logic teletextInsertOn,
  input wire logic [8:0] lineCount,
  input wire logic [10:0] pixelCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] hStart_r;
  logic [10:0] hEnd_r;
  logic [7:0] reqStart_r;
  logic [7:0] vShift_r;
  logic [10:0] pixLast;
  assign pixLast = pinCfg.fieldRateSelect ? vlt_pkg::PIX_LAST_60 : vlt_pkg::PIX_LAST_50;
  // Shadow copies of the timing registers, tracked from the write strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hStart_r <= '0;
      hEnd_r <= '0;
      reqStart_r <= '0;
      vShift_r <= '0;
    end else if (regWr.en) begin
      case (regWr.addr)
        8'h70: hStart_r[7:0] <= regWr.data;
        8'h71: hEnd_r[7:0] <= regWr.data;
        8'h72: begin
          hStart_r[10:8] <= regWr.data[2:0];
          hEnd_r[10:8] <= regWr.data[6:4];
        end
        8'h73: reqStart_r <= regWr.data;
        8'h75: vShift_r <= regWr.data;
        default: ;
      endcase
    end
  end
  // Consecutive request cycles; a counter keeps the length check cheap to unroll
  logic [4:0] reqRun_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqRun_r <= '0;
    end else begin
      reqRun_r <= teletextRequestOut ? reqRun_r + 5'h1 : 5'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence reqDone;
    $fell(teletextRequestOut);
  endsequence
  // The first four cycles after reset release are skipped; the reset is asynchronous
  pix_wrap_a: assert property ($past(rst_n, 4) && pixelCount == pixLast |=> pixelCount == 11'h0)
    else $error("pixel counter did not wrap");
  pix_step_a: assert property ($past(rst_n, 4) && pixelCount < pixLast |=>
    pixelCount == $past(pixelCount) + 11'h1) else $error("pixel counter skipped");
  line_max_a: assert property (lineCount <= (pinCfg.fieldRateSelect ? 9'h106 : 9'h138))
    else $error("line count beyond field length");
  href_on_a: assert property (pinCfg.syncPinBOutEn && !pinCfg.compositeBlankSelect &&
    hStart_r != hEnd_r && pixelCount == hStart_r |=> syncPinBOut) else $error("href late");
  href_off_a: assert property (hStart_r != hEnd_r && pixelCount == hEnd_r |=> !syncPinBOut)
    else $error("href did not end");
  req_len_a: assert property (reqDone |-> reqRun_r == 5'h10)
    else $error("request length wrong");
  req_max_a: assert property (teletextRequestOut |-> reqRun_r < 5'h10)
    else $error("request too long");
  req_pos_a: assert property ($rose(teletextRequestOut) |->
    $past(pixelCount) == {3'h0, reqStart_r}) else $error("request at wrong pixel");
  req_gate_a: assert property (!teletextInsertOn |-> !$rose(teletextRequestOut))
    else $error("request while insertion off");
  vs_rise_a: assert property (pinCfg.syncPinAOutEn && lineCount == 9'h0 &&
    pixelCount == {3'h0, vShift_r} |=> syncPinAOut) else $error("vsync not started");
  vs_hold_a: assert property (pinCfg.syncPinAOutEn && lineCount == 9'h2 |-> syncPinAOut)
    else $error("vsync dropped");
  buf_stall_a: assert property ($past(rst_n, 4) && ttxBitValid && !ttxBitReady |=> ttxBitValid)
    else $error("word lost under stall");
  buf_full_a: assert property (!ttxBufReady && !ttxBitReady |=>
    !ttxBufReady && $stable(ttxBitData)) else $error("full buffer lost its head");
endmodule
bind vlt_line_timing vlt_line_timing_sva vlt_line_timing_sva_inst (.clk(clk), .rst_n(rst_n),
  .regWr(regWr), .pinCfg(pinCfg), .syncPinAOut(syncPinAOut), .syncPinBOut(syncPinBOut),
  .teletextRequestOut(teletextRequestOut), .ttxBitValid(ttxBitValid),
  .ttxBitReady(ttxBitReady), .ttxBitData(ttxBitData), .ttxBufReady(ttxBufReady),
  .teletextInsertOn(teletextInsertOn), .lineCount(lineCount), .pixelCount(pixelCount));

/* verification/vlt_ttx_source.sv */
// Model of the external teletext source on the data pin
module vlt_ttx_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the block and the programmed delay
  input wire logic teletextRequestOut,
  input wire logic [7:0] dataDelay,
  // Serial data toward the block
  output logic teletextDataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic reqPrev_r;
  logic busy_r;
  logic [8:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqPrev_r <= 1'b0;
      busy_r <= 1'b0;
      cnt_r <= '0;
      teletextDataIn <= 1'b0;
    end else begin
      reqPrev_r <= teletextRequestOut;
      if (teletextRequestOut && !reqPrev_r) begin
        busy_r <= 1'b1;
        cnt_r <= 9'h1;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 9'h1;
        busy_r <= cnt_r != 9'h28;
      end
      // Ones cover the sampling window with margin for the pin filter delay
      teletextDataIn <= busy_r && cnt_r + 9'h5 >= {1'b0, dataDelay} &&
        cnt_r <= {1'b0, dataDelay} + 9'hC;
    end
  end
endmodule

/* verification/tb_top.sv */
// Self-checking testbench of the VBI line timing block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  vlt_pkg::vlt_regwr_t regWr = '0;
  vlt_pkg::vlt_pincfg_t pinCfg = '0;
  logic [7:0] regRdAddr = 8'h00;
  logic [7:0] regRdData;
  logic syncPinAOut, syncPinAOe, syncPinBOut, syncPinBOe, teletextRequestOut, teletextDataIn;
  logic ttxBitValid, ttxBufReady, teletextInsertOn, activeLine, captionLine, evenField;
  logic ttxBitReady = 1'b1;
  logic [1:0] lineMaskOff = 2'h0;
  logic [vlt_pkg::TTX_WORD_W-1:0] ttxBitData;
  logic [1:0] teletextStandard;
  logic [8:0] lineCount;
  logic [10:0] pixelCount;
  int errCount = 0;
  int totalChecks = 0;
  always #5 clk = ~clk;
  vlt_line_timing vlt_line_timing_inst (.clk(clk), .rst_n(rst_n), .regWr(regWr),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .pinCfg(pinCfg), .syncPinAType(2'h0),
    .syncPinAIn(1'b0), .syncPinAOut(syncPinAOut), .syncPinAOe(syncPinAOe), .syncPinBIn(1'b0),
    .syncPinBOut(syncPinBOut), .syncPinBOe(syncPinBOe), .teletextRequestOut(teletextRequestOut),
    .teletextDataIn(teletextDataIn), .teletextLineMaskOff(lineMaskOff), .ttxBitValid(ttxBitValid),
    .ttxBitReady(ttxBitReady), .ttxBitData(ttxBitData), .ttxBufReady(ttxBufReady),
    .teletextStandard(teletextStandard), .teletextInsertOn(teletextInsertOn),
    .activeLine(activeLine), .captionLine(captionLine), .evenField(evenField),
    .lineCount(lineCount), .pixelCount(pixelCount));
  vlt_ttx_source vlt_ttx_source_inst (.clk(clk), .rst_n(rst_n), .dataDelay(8'h08),
    .teletextRequestOut(teletextRequestOut), .teletextDataIn(teletextDataIn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic doReset(input logic field_rate_select);
    @(negedge clk);
    rst_n = 1'b0;
    pinCfg = '{field_rate_select, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWr = '{1'b1, a, d};
    @(negedge clk);
    regWr.en = 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    regRdAddr = a;
    @(negedge clk);
    chk(regRdData, e);
  endtask
  task automatic waitAt(input logic [8:0] l, input logic [10:0] p);
    int n = 0;
    while (!(lineCount === l && pixelCount === p) && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) chk(32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic tRegs();
    doReset(1'b0);
    for (int i = 0; i < 14; i++) begin
      rdChk(8'h6F + i[7:0], 8'h00);
      wr(8'h6F + i[7:0], 8'h5A ^ i[7:0]);
      rdChk(8'h6F + i[7:0], 8'h5A ^ i[7:0]);
    end
    wr(8'h6E, 8'hFF);
    rdChk(8'h6E, 8'h00);
    rdChk(8'h7D, 8'h00);
    $display("test regs done");
  endtask
  task automatic tStd();
    doReset(1'b0);
    wr(8'h7C, 8'h20);
    wr(8'h6F, 8'h20);
    @(negedge clk);
    chk(teletextStandard, vlt_pkg::TTX_STD_EUROPEAN);
    chk(teletextInsertOn, 1'b1);
    doReset(1'b1);
    chk(teletextStandard, vlt_pkg::TTX_STD_NABTS);
    chk(teletextInsertOn, 1'b0);
    wr(8'h7C, 8'h20);
    @(negedge clk);
    chk(teletextStandard, vlt_pkg::TTX_STD_WORLD60);
    $display("test standard done");
  endtask
  task automatic tHref(input logic field_rate_select, input logic [10:0] s, input logic [10:0] e);
    int hi = 0;
    doReset(field_rate_select);
    wr(8'h70, s[7:0]);
    wr(8'h71, e[7:0]);
    wr(8'h72, {1'b0, e[10:8], 1'b0, s[10:8]});
    waitAt(9'h001, s);
    chk(syncPinBOut, 1'b0);
    repeat (e - s + 11'h8) begin
      @(negedge clk);
      if (syncPinBOut === 1'b1) hi++;
    end
    chk(hi, e - s);
    chk(syncPinBOe, 1'b1);
    chk(syncPinAOe, 1'b1);
    // No active line is programmed, so blanking gating must hide the pulse
    pinCfg.compositeBlankSelect = 1'b1;
    waitAt(9'h002, e);
    chk(syncPinBOut, 1'b0);
    $display("test href done");
  endtask
  task automatic tVert(input logic field_rate_select);
    logic [8:0] f;
    logic [8:0] t;
    f = field_rate_select ? 9'h4 : 9'h1;
    t = field_rate_select ? 9'h5 : 9'h2;
    doReset(field_rate_select);
    wr(8'h6F, 8'h42);
    wr(8'h7B, 8'h02);
    for (int i = 0; i < 8; i++) begin
      waitAt(i[8:0], 11'h0064);
      chk(activeLine, i[8:0] >= f && i[8:0] <= t);
      chk(captionLine, i[8:0] == 9'h2 + f);
      chk(evenField, 1'b0);
    end
    wr(8'h7B, 8'h20);
    repeat (2) @(negedge clk);
    chk(activeLine, 1'b1);
    pinCfg.standardBlankingForce = 1'b1;
    repeat (2) @(negedge clk);
    chk(activeLine, 1'b0);
    $display("test vertical done");
  endtask
  task automatic tTtx();
    int n = 0;
    int m = 0;
    doReset(1'b0);
    wr(8'h77, 8'h03);
    wr(8'h73, 8'h42);
    wr(8'h74, 8'h08);
    wr(8'h6F, 8'h20);
    waitAt(9'h000, 11'h0044);
    chk(teletextRequestOut, 1'b0);
    waitAt(9'h001, 11'h0042);
    chk(teletextRequestOut, 1'b0);
    @(negedge clk);
    chk(teletextRequestOut, 1'b1);
    repeat (40) begin
      if (ttxBitValid === 1'b1) n++;
      if (ttxBitValid === 1'b1 && ttxBitData === 1'b1) m++;
      @(negedge clk);
    end
    chk(n, 16);
    chk(m, 16);
    ttxBitReady = 1'b0;
    waitAt(9'h002, 11'h0080);
    chk(ttxBufReady, 1'b0);
    ttxBitReady = 1'b1;
    n = 0;
    repeat (8) begin
      if (ttxBitValid === 1'b1) n++;
      @(negedge clk);
    end
    chk(n, 2);
    lineMaskOff = 2'h1;
    waitAt(9'h003, 11'h0044);
    chk(teletextRequestOut, 1'b0);
    lineMaskOff = 2'h0;
    waitAt(9'h004, 11'h0044);
    chk(teletextRequestOut, 1'b0);
    $display("test teletext done");
  endtask
  initial begin
    tRegs();
    tStd();
    tHref(1'b0, 11'h0FD, 11'h687);
    tHref(1'b1, 11'h11A, 11'h694);
    tVert(1'b0);
    tVert(1'b1);
    tTtx();
    reportAndStop();
  end
  // Roughly twice the expected run length
  initial begin
    #900_000;
    errCount++;
    reportAndStop();
  end
endmodule
